// File: rtc_tone_chime_map.vh
// Constants for the seconds/tone/chime unit: offsets, fields, resets, counts.
// Assumes a 12-bit byte address on the plain register port.
// Functional notes
// - Tone frequency is slow rate over 2N+4; N is 1..4095, zero is prohibited.
// - Tone or chime waveform drives the output pin; its twin carries the complement.
// - Run bit reads back stale until loaded at the next slow clock tick.
// - Chime waveforms run from a 4096 Hz tick divided from the slow clock.
// - Shape select is one-hot; zero holds low; other codes undefined.
// - Chime counter gives periodic events at 1, 2, 64, 512 and 8192 Hz.
// - Seconds counter is 32 bits and increments on a 1 Hz slow-clock tick.
// - Reading the seconds count register returns the live seconds counter.
// - Seconds counter equal to match value raises interrupt and wake request.
// - Writing the seconds load register replaces the seconds counter contents.
// - Seconds counter always counts and can request power resume on its own.
// - Source select: 00 stop, 01 tone, 10 chime; 11 not to be used.
// - Output invert bit set inverts the output; clear passes it unchanged.
// - Chime counter run bit zero clears and stops it; one starts it.
// - Tone counter run bit zero clears and stops it; one starts it.
`ifndef RTC_TONE_CHIME_MAP_VH
`define RTC_TONE_CHIME_MAP_VH

`define ADDR_W           12
`define SECONDS_COUNT    12'h000
`define SECONDS_MATCH    12'h004
`define SECONDS_LOAD     12'h008
`define OUT_INVERT       12'h100
`define OUT_SOURCE       12'h104
`define CHIME_CTRL       12'h108
`define CHIME_SHAPE      12'h10C
`define TONE_CTRL        12'h110
`define TONE_DIVIDER     12'h114
`define INT_MASK         12'h200
`define INT_STATUS       12'h204

`define SRC_STOP         2'h0
`define SRC_TONE         2'h1
`define SRC_CHIME        2'h2

`define INT_W            6
`define INT_MATCH_BIT    0
`define RST_INVERT       1'h0
`define RST_SOURCE       2'h0
`define RST_RUN          1'h0
`define RST_SHAPE        8'h00
`define RST_DIVIDER      12'h000
`define RST_MASK         6'h00

`define SLOW_HZ          32768
`define CHIME_BASE_HZ    4096
`define CHIME_BASE_BIT   2
`define SEC_PRESCALE_MAX 15'h7FFF

`endif

// File: seconds_tone_chime_unit.v
// Seconds counter, tone generator and chime generator with interrupts.
// Assumes slow_crystal_in is a free-running 32.768 kHz level, sampled on clk.
`timescale 1ns/1ps
`include "rtc_tone_chime_map.vh"

module seconds_tone_chime_unit (
  input  wire                 clk,
  input  wire                 rst,
  input  wire                 slow_crystal_in,
  input  wire [`ADDR_W-1:0]   addr,
  input  wire [31:0]          wdata,
  input  wire                 wr,
  input  wire                 rd,
  output reg  [31:0]          rdata,
  output wire                 irq,
  output wire                 power_resume_req,
  output reg                  tone_chime_out,
  output reg                  tone_chime_out_inv
);

  // Divider exponents for status bits 1..5: 8192, 512, 64, 2, 1 Hz
  localparam [19:0] EVT_BITS = {4'hF, 4'hE, 4'h9, 4'h6, 4'h2};

  // Offset compare, shared by every write strobe below
  function reg_hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] offs;
    begin
      reg_hit = (a == offs);
    end
  endfunction

  function all_low_ones;
    input [14:0] cnt;
    input [3:0]  nbits;
    integer      i;
    begin
      all_low_ones = 1'b1;
      for (i = 0; i < 15; i = i + 1) begin
        if (i < nbits && !cnt[i]) begin
          all_low_ones = 1'b0;
        end
      end
    end
  endfunction

  // Slow clock edge detect; first stage feeds only the second
  reg        slow_s1_q;
  reg        slow_s2_q;
  reg        slow_s3_q;
  wire       slow_tick = slow_s2_q & ~slow_s3_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      slow_s1_q <= 1'b0;
      slow_s2_q <= 1'b0;
      slow_s3_q <= 1'b0;
    end else begin
      slow_s1_q <= slow_crystal_in;
      slow_s2_q <= slow_s1_q;
      slow_s3_q <= slow_s2_q;
    end
  end

  // Staged writes, applied on the next slow tick like the real slow-domain loader
  reg [31:0] match_q;
  reg [31:0] load_val_q;
  reg        load_pend_q;
  reg        inv_stage_q;
  reg [1:0]  src_stage_q;
  reg [7:0]  shape_stage_q;
  reg [11:0] div_stage_q;
  reg        tone_run_stage_q;
  reg        chime_run_stage_q;
  reg        inv_q;
  reg [1:0]  src_q;
  reg [7:0]  shape_q;
  reg [11:0] div_q;
  reg        tone_run_q;
  reg        chime_run_q;
  reg [`INT_W-1:0] mask_q;
  reg [`INT_W-1:0] status_q;

  wire wr_match  = wr && reg_hit(addr, `SECONDS_MATCH);
  wire wr_load   = wr && reg_hit(addr, `SECONDS_LOAD);
  wire wr_inv    = wr && reg_hit(addr, `OUT_INVERT);
  wire wr_src    = wr && reg_hit(addr, `OUT_SOURCE);
  wire wr_crun   = wr && reg_hit(addr, `CHIME_CTRL);
  wire wr_shape  = wr && reg_hit(addr, `CHIME_SHAPE);
  wire wr_trun   = wr && reg_hit(addr, `TONE_CTRL);
  wire wr_div    = wr && reg_hit(addr, `TONE_DIVIDER);
  wire wr_mask   = wr && reg_hit(addr, `INT_MASK);
  wire wr_status = wr && reg_hit(addr, `INT_STATUS);

  // Match is used at once; no slow-domain loader in its path
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      match_q <= 32'h0000_0000;
    end else if (wr_match) begin
      match_q <= wdata;
    end
  end

  // Load value waits here until the next slow tick
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      load_val_q <= 32'h0000_0000;
    end else if (wr_load) begin
      load_val_q <= wdata;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      inv_stage_q <= `RST_INVERT;
    end else if (wr_inv) begin
      inv_stage_q <= wdata[0];
    end
  end

  // Code 11 is kept as written; the selector treats it as stop
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      src_stage_q <= `RST_SOURCE;
    end else if (wr_src) begin
      src_stage_q <= wdata[1:0];
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      chime_run_stage_q <= `RST_RUN;
    end else if (wr_crun) begin
      chime_run_stage_q <= wdata[0];
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shape_stage_q <= `RST_SHAPE;
    end else if (wr_shape) begin
      shape_stage_q <= wdata[7:0];
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tone_run_stage_q <= `RST_RUN;
    end else if (wr_trun) begin
      tone_run_stage_q <= wdata[0];
    end
  end

  // Zero is not refused; it gives a four-tick period
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_stage_q <= `RST_DIVIDER;
    end else if (wr_div) begin
      div_stage_q <= wdata[11:0];
    end
  end

  // Mask lives in the fast domain, so it reads back at once
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= `RST_MASK;
    end else if (wr_mask) begin
      mask_q <= wdata[`INT_W-1:0];
    end
  end

  // Live copies change only on a slow tick; software must allow for that
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      inv_q       <= `RST_INVERT;
      src_q       <= `RST_SOURCE;
      shape_q     <= `RST_SHAPE;
      div_q       <= `RST_DIVIDER;
      tone_run_q  <= `RST_RUN;
      chime_run_q <= `RST_RUN;
    end else if (slow_tick) begin
      inv_q       <= inv_stage_q;
      src_q       <= src_stage_q;
      shape_q     <= shape_stage_q;
      div_q       <= div_stage_q;
      tone_run_q  <= tone_run_stage_q;
      chime_run_q <= chime_run_stage_q;
    end
  end

  // Seconds prescaler and counter never stop
  reg [14:0] sec_pre_q;
  reg [31:0] secs_q;
  reg        secs_upd_q;

  // Prescaler is not reset by a load, so the phase of the second is kept
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_pre_q <= 15'h0000;
    end else if (slow_tick) begin
      sec_pre_q <= sec_pre_q + 15'h0001;
    end
  end

  // A write in the tick cycle is applied at the following tick
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      load_pend_q <= 1'b0;
    end else if (wr_load) begin
      load_pend_q <= 1'b1;
    end else if (slow_tick) begin
      load_pend_q <= 1'b0;
    end
  end

  // Load beats the increment when both fall on one tick
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      secs_q     <= 32'h0000_0000;
      secs_upd_q <= 1'b0;
    end else begin
      secs_upd_q <= 1'b0;
      if (slow_tick && load_pend_q) begin
        secs_q     <= load_val_q;
        secs_upd_q <= 1'b1;
      end else if (slow_tick && sec_pre_q == `SEC_PRESCALE_MAX) begin
        secs_q     <= secs_q + 32'h0000_0001;
        secs_upd_q <= 1'b1;
      end
    end
  end

  // Checked once per change, so a held match fires only one event
  wire match_evt = secs_upd_q && secs_q == match_q;

  // Chime free-running counter
  reg [14:0] chime_cnt_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      chime_cnt_q <= 15'h0000;
    end else if (!chime_run_q) begin
      chime_cnt_q <= 15'h0000;
    end else if (slow_tick) begin
      chime_cnt_q <= chime_cnt_q + 15'h0001;
    end
  end

  wire [`INT_W-1:0] evt;
  assign evt[`INT_MATCH_BIT] = match_evt;

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : periodic
      assign evt[g+1] = chime_run_q && slow_tick &&
                        all_low_ones(chime_cnt_q, EVT_BITS[4*g+3:4*g]);
    end
  endgenerate

  // 4096 Hz carrier gated by slower envelopes; one pattern per select bit
  wire       carrier = chime_cnt_q[`CHIME_BASE_BIT];
  wire [7:0] pattern;

  generate
    for (g = 0; g < 8; g = g + 1) begin : shapes
      assign pattern[g] = carrier & chime_cnt_q[14-g];
    end
  endgenerate

  // Illegal multi-bit codes OR patterns together; output is undefined anyway
  wire chime_wave = |(shape_q & pattern);

  // Tone: toggle after N+2 ticks; 13 bits so N+1 fits for N = 4095
  reg [12:0] tone_cnt_q;
  reg        tone_q;
  wire [12:0] tone_last = {1'b0, div_q} + 13'h0001;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tone_cnt_q <= 13'h0000;
      tone_q     <= 1'b0;
    end else if (!tone_run_q) begin
      tone_cnt_q <= 13'h0000;
      tone_q     <= 1'b0;
    end else if (slow_tick) begin
      if (tone_cnt_q >= tone_last) begin
        tone_cnt_q <= 13'h0000;
        tone_q     <= ~tone_q;
      end else begin
        tone_cnt_q <= tone_cnt_q + 13'h0001;
      end
    end
  end

  // Output select, invert and pin pair
  reg src_wave;

  always @* begin
    case (src_q)
      `SRC_TONE:  src_wave = tone_q;
      `SRC_CHIME: src_wave = chime_wave;
      default:    src_wave = 1'b0;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tone_chime_out     <= 1'b0;
      tone_chime_out_inv <= 1'b1;
    end else begin
      tone_chime_out     <= src_wave ^ inv_q;
      tone_chime_out_inv <= ~(src_wave ^ inv_q);
    end
  end

  // Sticky status; a new event beats a same-cycle clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= {`INT_W{1'b0}};
    end else begin
      status_q <= (status_q & ~(wr_status ? wdata[`INT_W-1:0] : {`INT_W{1'b0}})) | evt;
    end
  end

  assign irq              = |(status_q & mask_q);
  assign power_resume_req = status_q[`INT_MATCH_BIT];

  // Read port; write-only and unmapped offsets read zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `SECONDS_COUNT: rdata <= secs_q;
        `CHIME_CTRL:    rdata <= {31'h0000_0000, chime_run_q};
        `TONE_CTRL:     rdata <= {31'h0000_0000, tone_run_q};
        `INT_MASK:      rdata <= {26'h000_0000, mask_q};
        `INT_STATUS:    rdata <= {26'h000_0000, status_q};
        default:        rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule

// File: unit_properties.sv
// Pin checker for the seconds, tone and chime unit.
// Assumes the crystal period exceeds six clk cycles.
`timescale 1ns/1ps
`include "rtc_tone_chime_map.vh"
module unit_properties (
  input wire               clk,
  input wire               rst,
  input wire               slow_crystal_in,
  input wire [`ADDR_W-1:0] addr,
  input wire [31:0]        wdata,
  input wire               wr,
  input wire               rd,
  input wire [31:0]        rdata,
  input wire               irq,
  input wire               power_resume_req,
  input wire               tone_chime_out,
  input wire               tone_chime_out_inv
);
  logic [3:0] since_q;
  logic       slow_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles since the crystal rose; saturates so it never wraps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_q <= 4'h0;
      slow_q  <= 1'h0;
    end else begin
      slow_q  <= slow_crystal_in;
      since_q <= (slow_crystal_in && !slow_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hF};
    end
  end
  AST_TWIN: assert property (tone_chime_out_inv == !tone_chime_out)
    else $error("twin pin not complement");
  AST_RDATA_IDLE: assert property (!rd |=> rdata == 32'h0)
    else $error("read data without read");
  AST_RUN_UPPER: assert property (rd && addr == `TONE_CTRL |=> rdata[31:1] == 31'h0)
    else $error("run register upper bits set");
  AST_WO_ZERO: assert property (rd && addr == `SECONDS_MATCH |=> rdata == 32'h0)
    else $error("match register readable");
  AST_STATUS_PIN: assert property (
    rd && addr == `INT_STATUS |=> rdata[0] == $past(power_resume_req))
    else $error("resume pin differs from status");
  AST_IRQ_CAUSE: assert property (
    rd && addr == `INT_STATUS && irq |=> rdata[5:0] != 6'h00)
    else $error("irq with empty status");
  AST_RESUME_STICKY: assert property (
    power_resume_req && !(wr && addr == `INT_STATUS && wdata[0]) |=> power_resume_req)
    else $error("resume request dropped");
  AST_SLOW_PACE: assert property ($changed(tone_chime_out) |-> since_q <= 4'h6)
    else $error("output moved off slow tick");
endmodule
bind seconds_tone_chime_unit unit_properties i_unit_properties (
  .clk, .rst, .slow_crystal_in, .addr, .wdata, .wr, .rd, .rdata, .irq,
  .power_resume_req, .tone_chime_out, .tone_chime_out_inv);

// File: crystal_buzzer_model.sv
// Crystal source and buzzer-side edge timer.
// Assumes one clk domain; crystal runs free at eight clk a cycle.
`timescale 1ns/1ps
module crystal_buzzer_model (
  input  logic        clk,
  input  logic        tone_in,
  output logic        slow_crystal_in = 1'h0,
  output logic [15:0] half_len = 16'h0000
);
  logic [1:0]  div_q = 2'h0;
  logic [15:0] cnt_q = 16'h0000;
  logic        tone_q = 1'h0;
  always @(posedge clk) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3)
      slow_crystal_in <= !slow_crystal_in;
    tone_q <= tone_in;
    cnt_q  <= (tone_in != tone_q) ? 16'h0001 : cnt_q + 16'h0001;
    if (tone_in != tone_q)
      half_len <= cnt_q;
  end
endmodule

// File: test_seconds_tone_chime_unit.sv
// Bench for the seconds, tone and chime unit.
// Assumes the partner model sets the crystal at eight clk a cycle.
`timescale 1ns/1ps
`include "rtc_tone_chime_map.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module test_seconds_tone_chime_unit;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic        rd_d = 1'h0;
  logic [31:0] rdata, v, e;
  logic        irq, pr, out, out_inv, slow;
  logic [15:0] half_len;
  logic [31:0] exp_q[$];
  int          errors = 0;
  int          cmp_count = 0;
  int          n;
  seconds_tone_chime_unit i_seconds_tone_chime_unit (.clk, .rst, .slow_crystal_in(slow),
    .addr, .wdata, .wr, .rd, .rdata, .irq, .power_resume_req(pr),
    .tone_chime_out(out), .tone_chime_out_inv(out_inv));
  crystal_buzzer_model i_crystal_buzzer_model (.clk, .tone_in(out),
    .slow_crystal_in(slow), .half_len);
  always #4 clk = !clk;
  // One assignment per signal per edge, so back-to-back calls never race
  task bus(input logic w, r, input logic [11:0] a, input logic [31:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task idle(input int c);
    repeat (c) bus(1'h0, 1'h0, 12'h000, 32'h0);
  endtask
  task wreg(input logic [11:0] a, input logic [31:0] d);
    bus(1'h1, 1'h0, a, d);
  endtask
  task rdx(input logic [11:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    bus(1'h0, 1'h1, a, 32'h0);
  endtask
  task poll(input logic [11:0] a, input logic [31:0] x);
    v = ~x;
    for (int i = 0; i < 40 && v !== x; i++) begin
      bus(1'h0, 1'h1, a, 32'h0);
      idle(1);
      v = rdata;
    end
    `CHK("poll", x, v)
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      `CHK("rdata", e, rdata)
    end
  end
  initial begin
    void'($urandom(32'h44180e09));
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    idle(1);
    `CHK("out", 1'h0, out)
    `CHK("inv", 1'h1, out_inv)
    `CHK("irq", 1'h0, irq)
    rdx(`TONE_CTRL, 32'h0);
    rdx(`CHIME_CTRL, 32'h0);
    rdx(`SECONDS_MATCH, 32'h0);
    rdx(12'h300, 32'h0);
    $display("reset test done");
    for (int k = 0; k < 2; k++) begin
      n = k ? $urandom % 15 + 1 : 1;
      @(posedge slow);
      idle(5);
      // Just past a slow tick, so the run bit is still stale next cycle
      wreg(`TONE_DIVIDER, n);
      wreg(`OUT_SOURCE, {30'h0, `SRC_TONE});
      wreg(`TONE_CTRL, 32'h1);
      rdx(`TONE_CTRL, 32'h0);
      poll(`TONE_CTRL, 32'h1);
      idle((n + 2) * 24);
      `CHK("half", 16'((n + 2) * 8), half_len)
      wreg(`TONE_CTRL, 32'h0);
      poll(`TONE_CTRL, 32'h0);
      idle(8);
      `CHK("stop", 1'h0, out)
    end
    wreg(`OUT_SOURCE, {30'h0, `SRC_STOP});
    wreg(`OUT_INVERT, 32'h1);
    idle(40);
    `CHK("inv_out", 1'h1, out)
    `CHK("inv_twin", 1'h0, out_inv)
    wreg(`OUT_INVERT, 32'h0);
    $display("tone test done");
    wreg(`OUT_SOURCE, {30'h0, `SRC_CHIME});
    wreg(`CHIME_SHAPE, 32'h0);
    wreg(`CHIME_CTRL, 32'h1);
    poll(`CHIME_CTRL, 32'h1);
    idle(600);
    `CHK("shape0", 1'h0, out)
    rdx(`INT_STATUS, 32'h6);
    wreg(`CHIME_CTRL, 32'h0);
    poll(`CHIME_CTRL, 32'h0);
    wreg(`INT_STATUS, 32'h3F);
    rdx(`INT_STATUS, 32'h0);
    $display("chime test done");
    v = $urandom;
    wreg(`INT_MASK, 32'h1);
    wreg(`SECONDS_MATCH, v);
    wreg(`SECONDS_LOAD, v);
    idle(40);
    rdx(`SECONDS_COUNT, v);
    rdx(`INT_STATUS, 32'h1);
    idle(1);
    `CHK("wake", 1'h1, pr)
    `CHK("irq", 1'h1, irq)
    wreg(`INT_MASK, 32'h0);
    idle(2);
    `CHK("masked", 1'h0, irq)
    wreg(`INT_STATUS, 32'h1);
    idle(2);
    `CHK("cleared", 1'h0, pr)
    $display("seconds test done");
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end
endmodule
